// ==== design/tcb_config_bank.sv ====
// configuration byte bank of a passive low-frequency transponder
// assumes the command decoder delivers one-cycle byte read/write strobes
// and one-cycle select/exchange results, all synchronous to clock_i
//
// Overview of operation
// - stored settings take effect after power-on reset
// - memory type byte reports size code
// - memory type byte read-only, upper bits reserved
// - plain mode: matching select selects directly
// - authenticated mode: select then successful exchange
// - talks-first coding: manchester or biphase
// - talks-first rate codes give 4, 8, 2 kbit/s
// - rate code 11: 2 kbit/s plus pigeon race
// - page count sets talks-first pages or disables
// - configuration lock returns to zero only on hardware reset
// - lock set: mode byte read-only, page-lock otp
// - secret lock restricts key and password access
`timescale 1ns/100ps
`default_nettype none
`include "tcb_consts.svh"

module tcb_config_bank
    import tcb_pkg::*;
#(
    parameter logic [1:0] MEM_SIZE_CODE = `TCB_MEM_SIZE_DEF
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // power-on event of the transponder
    input wire logic por_i,
    // memory command port
    input wire logic rd_en_i,
    input wire logic wr_en_i,
    input wire logic [1:0] byte_sel_i,
    input wire logic [7:0] wr_data_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic wr_ack_o,
    output logic wr_refused_o,
    // selection events
    input wire logic select_ok_i,
    input wire logic auth_ok_i,
    input wire logic auth_fail_i,
    input wire logic quiet_i,
    output logic selected_o,
    output logic auth_mode_o,
    // talks-first uplink settings
    output logic ttf_enable_o,
    output logic uplink_biphase_o,
    output logic pigeon_race_o,
    output logic [6:0] bit_len_o,
    output logic [5:0] ttf_last_page_o,
    // key and password access
    output logic secret_rd_ok_o,
    output logic secret_wr_ok_o,
    output logic config_locked_o
);

    localparam tcb_state_t ST_RST = '{
        stored_mode: tcb_mode_t'(`TCB_MODE_RST),
        stored_plock: `TCB_PLOCK_RST,
        act_mode: tcb_mode_t'(`TCB_MODE_RST),
        load_pend: 1'b1,
        sel_state: TCB_SEL_IDLE,
        selected: 1'b0,
        rd_data: `TCB_RD_RST,
        rd_valid: 1'b0,
        wr_ack: 1'b0,
        wr_refused: 1'b0,
        uplink: '{ttf_en: 1'b0, biphase: 1'b0, pigeon: 1'b0,
                  bit_len: `TCB_BITLEN_4K, last_page: `TCB_TTF_FIRST_PAGE},
        secret_rd: 1'b1,
        secret_wr: 1'b1
    };

    tcb_state_t st_r;
    tcb_state_t st_nxt;
    tcb_uplink_t dec_uplink;
    logic act_locked;

    tcb_uplink_decode u_dec (
        .mode_i(st_r.act_mode),
        .uplink_o(dec_uplink)
    );

    // access rights follow the power-on copy, not the freshly written byte
    assign act_locked = st_r.act_mode.config_lock;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rd_valid = 1'b0;
        st_nxt.wr_ack = 1'b0;
        st_nxt.wr_refused = 1'b0;

        // power-on copy; also taken once after the hardware reset release
        if (por_i || st_r.load_pend)
        begin
            st_nxt.act_mode = st_r.stored_mode;
            st_nxt.load_pend = 1'b0;
            st_nxt.sel_state = TCB_SEL_IDLE;
        end

        if (rd_en_i)
        begin
            st_nxt.rd_valid = 1'b1;
            case (byte_sel_i)
                `TCB_SEL_MEMTYPE: st_nxt.rd_data = {6'h00, MEM_SIZE_CODE};
                `TCB_SEL_MODE: st_nxt.rd_data = st_r.stored_mode;
                `TCB_SEL_PLOCK: st_nxt.rd_data = st_r.stored_plock;
                default: st_nxt.rd_data = 8'h00;
            endcase
        end
        else if (wr_en_i)
        begin
            case (byte_sel_i)
                `TCB_SEL_MODE:
                begin
                    if (act_locked)
                        st_nxt.wr_refused = 1'b1;
                    else
                    begin
                        st_nxt.wr_ack = 1'b1;
                        st_nxt.stored_mode = tcb_mode_t'(wr_data_i);
                        // lock bit is one-time programmable
                        st_nxt.stored_mode.config_lock =
                            st_r.stored_mode.config_lock | wr_data_i[1];
                    end
                end
                `TCB_SEL_PLOCK:
                begin
                    st_nxt.wr_ack = 1'b1;
                    if (act_locked)
                        st_nxt.stored_plock = st_r.stored_plock | wr_data_i;
                    else
                        st_nxt.stored_plock = wr_data_i;
                end
                default: st_nxt.wr_refused = 1'b1;
            endcase
        end

        // selection; quiet and power-on drop it
        if (!(por_i || st_r.load_pend))
        begin
            case (st_r.sel_state)
                TCB_SEL_IDLE:
                begin
                    if (select_ok_i && st_r.act_mode.aut)
                        st_nxt.sel_state = TCB_SEL_WAIT_AUTH;
                    else if (select_ok_i)
                        st_nxt.sel_state = TCB_SEL_DONE;
                end
                TCB_SEL_WAIT_AUTH:
                begin
                    if (auth_ok_i)
                        st_nxt.sel_state = TCB_SEL_DONE;
                    else if (auth_fail_i || quiet_i)
                        st_nxt.sel_state = TCB_SEL_IDLE;
                end
                TCB_SEL_DONE:
                begin
                    if (quiet_i)
                        st_nxt.sel_state = TCB_SEL_IDLE;
                end
                default: st_nxt.sel_state = TCB_SEL_IDLE;
            endcase
        end
        // registered copy so the output needs no decode after the flop
        st_nxt.selected = (st_nxt.sel_state == TCB_SEL_DONE);

        st_nxt.uplink = dec_uplink;
        // secret storage: open, read-only in plain, closed in authenticated
        st_nxt.secret_rd = !st_r.act_mode.secret_lock || !st_r.act_mode.aut;
        st_nxt.secret_wr = !st_r.act_mode.secret_lock;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            st_r <= ST_RST;
        else
            st_r <= st_nxt;
    end

    assign rd_data_o = st_r.rd_data;
    assign rd_valid_o = st_r.rd_valid;
    assign wr_ack_o = st_r.wr_ack;
    assign wr_refused_o = st_r.wr_refused;
    assign selected_o = st_r.selected;
    assign auth_mode_o = st_r.act_mode.aut;
    assign ttf_enable_o = st_r.uplink.ttf_en;
    assign uplink_biphase_o = st_r.uplink.biphase;
    assign pigeon_race_o = st_r.uplink.pigeon;
    assign bit_len_o = st_r.uplink.bit_len;
    assign ttf_last_page_o = st_r.uplink.last_page;
    assign secret_rd_ok_o = st_r.secret_rd;
    assign secret_wr_ok_o = st_r.secret_wr;
    assign config_locked_o = st_r.act_mode.config_lock;

    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    property p_no_early_apply;
        !por_i && !st_r.load_pend |=> $stable(st_r.act_mode);
    endproperty
    a_no_early_apply: assert property (p_no_early_apply)
        else $error("active config changed without power-on");

    property p_memtype_read;
        rd_en_i && byte_sel_i == `TCB_SEL_MEMTYPE |=>
            rd_valid_o && rd_data_o == {6'h00, MEM_SIZE_CODE};
    endproperty
    a_memtype_read: assert property (p_memtype_read)
        else $error("memory type byte read wrong");

    property p_memtype_ro;
        wr_en_i && !rd_en_i && byte_sel_i == `TCB_SEL_MEMTYPE |=> wr_refused_o && !wr_ack_o;
    endproperty
    a_memtype_ro: assert property (p_memtype_ro)
        else $error("memory type byte write not refused");

    property p_plain_select;
        !por_i && !st_r.load_pend && !st_r.act_mode.aut &&
            st_r.sel_state == TCB_SEL_IDLE && select_ok_i |=> selected_o;
    endproperty
    a_plain_select: assert property (p_plain_select)
        else $error("plain select did not select");

    property p_auth_select;
        st_r.act_mode.aut && st_r.sel_state == TCB_SEL_IDLE |=> !selected_o;
    endproperty
    a_auth_select: assert property (p_auth_select)
        else $error("selected without exchange");

    property p_coding;
        ##1 uplink_biphase_o == $past(st_r.act_mode.uplink_coding_sel);
    endproperty
    a_coding: assert property (p_coding)
        else $error("uplink coding mismatch");

    property p_rate;
        st_r.act_mode.uplink_rate_sel == `TCB_RATE_8K |=> bit_len_o == `TCB_BITLEN_8K;
    endproperty
    a_rate: assert property (p_rate)
        else $error("8 kbit rate not chosen");

    property p_pigeon;
        st_r.act_mode.uplink_rate_sel == `TCB_RATE_2K_PR |=>
            pigeon_race_o && bit_len_o == `TCB_BITLEN_2K;
    endproperty
    a_pigeon: assert property (p_pigeon)
        else $error("pigeon race setting wrong");

    property p_ttf_off;
        st_r.act_mode.uplink_page_count == `TCB_PAGES_OFF |=> !ttf_enable_o;
    endproperty
    a_ttf_off: assert property (p_ttf_off)
        else $error("talks-first not disabled");

    property p_lock_otp;
        st_r.stored_mode.config_lock |=> st_r.stored_mode.config_lock;
    endproperty
    a_lock_otp: assert property (p_lock_otp)
        else $error("configuration lock cleared");

    property p_mode_ro;
        act_locked && wr_en_i && !rd_en_i && byte_sel_i == `TCB_SEL_MODE |=>
            $stable(st_r.stored_mode) && wr_refused_o;
    endproperty
    a_mode_ro: assert property (p_mode_ro)
        else $error("locked mode byte written");

    property p_plock_keep;
        act_locked |=> (st_r.stored_plock & $past(st_r.stored_plock)) == $past(st_r.stored_plock);
    endproperty
    a_plock_keep: assert property (p_plock_keep)
        else $error("locked page-lock bit cleared");

    property p_secret;
        st_r.act_mode.secret_lock && st_r.act_mode.aut |=> !secret_rd_ok_o && !secret_wr_ok_o;
    endproperty
    a_secret: assert property (p_secret)
        else $error("secret storage open while locked");

    c_auth_path: cover property (select_ok_i && st_r.act_mode.aut ##[1:20] selected_o);
    c_lock_write: cover property (wr_en_i && byte_sel_i == `TCB_SEL_MODE && wr_data_i[1]);
    c_refused: cover property (wr_refused_o);

endmodule // tcb_config_bank
`default_nettype wire

// ==== design/tcb_consts.svh ====
// constants of the transponder configuration byte bank
// assumes nothing beyond a systemverilog compiler
`ifndef TCB_CONSTS_SVH
`define TCB_CONSTS_SVH

// byte selects within configuration page 1
`define TCB_SEL_MEMTYPE 2'h0
`define TCB_SEL_MODE 2'h1
`define TCB_SEL_PLOCK 2'h2
`define TCB_SEL_RESV 2'h3

// reset values
`define TCB_MODE_RST 8'h00
`define TCB_PLOCK_RST 8'h00
`define TCB_RD_RST 8'h00
`define TCB_MEM_SIZE_DEF 2'h1

// memory size codes
`define TCB_MEM_32 2'h0
`define TCB_MEM_256 2'h1
`define TCB_MEM_2048 2'h2

// uplink rate codes and bit lengths in carrier periods
`define TCB_RATE_4K 2'h0
`define TCB_RATE_8K 2'h1
`define TCB_RATE_2K 2'h2
`define TCB_RATE_2K_PR 2'h3
`define TCB_BITLEN_4K 7'h20
`define TCB_BITLEN_8K 7'h10
`define TCB_BITLEN_2K 7'h40

// uplink page count codes and page numbers
`define TCB_PAGES_OFF 2'h0
`define TCB_PAGES_TWO 2'h1
`define TCB_PAGES_FOUR 2'h2
`define TCB_PAGES_ONE 2'h3
`define TCB_TTF_FIRST_PAGE 6'h04
`define TCB_TTF_PAGE_5 6'h05
`define TCB_TTF_PAGE_7 6'h07

`endif

// ==== design/tcb_pkg.sv ====
// types of the transponder configuration byte bank
// assumes tcb_consts.svh for the numeric values
package tcb_pkg;

    // mode-and-lock byte, bit 7 down to bit 0
    typedef struct packed {
        logic aut;
        logic uplink_coding_sel;
        logic [1:0] uplink_rate_sel;
        logic [1:0] uplink_page_count;
        logic config_lock;
        logic secret_lock;
    } tcb_mode_t;

    typedef struct packed {
        logic ttf_en;
        logic biphase;
        logic pigeon;
        logic [6:0] bit_len;
        logic [5:0] last_page;
    } tcb_uplink_t;

    typedef enum logic [1:0] {
        TCB_SEL_IDLE = 2'b00,
        TCB_SEL_WAIT_AUTH = 2'b01,
        TCB_SEL_DONE = 2'b11
    } tcb_sel_state_t;

    typedef struct packed {
        tcb_mode_t stored_mode;
        logic [7:0] stored_plock;
        tcb_mode_t act_mode;
        logic load_pend;
        tcb_sel_state_t sel_state;
        logic selected;
        logic [7:0] rd_data;
        logic rd_valid;
        logic wr_ack;
        logic wr_refused;
        tcb_uplink_t uplink;
        logic secret_rd;
        logic secret_wr;
    } tcb_state_t;

endpackage

// ==== design/tcb_uplink_decode.sv ====
// decodes the active mode byte into talks-first uplink settings
// assumes the mode byte is already the power-on copy; purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "tcb_consts.svh"

module tcb_uplink_decode
    import tcb_pkg::*;
(
    // configuration in
    input wire tcb_mode_t mode_i,
    // decoded settings out
    output tcb_uplink_t uplink_o
);

    always_comb
    begin
        uplink_o.biphase = mode_i.uplink_coding_sel;
        uplink_o.pigeon = 1'b0;
        case (mode_i.uplink_rate_sel)
            `TCB_RATE_4K: uplink_o.bit_len = `TCB_BITLEN_4K;
            `TCB_RATE_8K: uplink_o.bit_len = `TCB_BITLEN_8K;
            `TCB_RATE_2K: uplink_o.bit_len = `TCB_BITLEN_2K;
            default:
            begin
                uplink_o.bit_len = `TCB_BITLEN_2K;
                uplink_o.pigeon = 1'b1;
            end
        endcase
        uplink_o.ttf_en = (mode_i.uplink_page_count != `TCB_PAGES_OFF);
        case (mode_i.uplink_page_count)
            `TCB_PAGES_TWO: uplink_o.last_page = `TCB_TTF_PAGE_5;
            `TCB_PAGES_FOUR: uplink_o.last_page = `TCB_TTF_PAGE_7;
            default: uplink_o.last_page = `TCB_TTF_FIRST_PAGE;
        endcase
    end

endmodule // tcb_uplink_decode
`default_nettype wire

// ==== bench/tcb_reader_model.sv ====
// reader/writer stand-in: byte commands and selection events
// assumes clock_i is the bank clock; outputs change at falling edges only
`timescale 1ns/100ps
`default_nettype none

module tcb_reader_model
(
    // clock
    input wire logic clock_i,
    // memory commands
    output logic rd_en_o,
    output logic wr_en_o,
    output logic [1:0] byte_sel_o,
    output logic [7:0] wr_data_o,
    // events: power-on, select, exchange ok, exchange fail, quiet
    output logic por_o,
    output logic select_o,
    output logic auth_ok_o,
    output logic auth_fail_o,
    output logic quiet_o
);
    initial
    begin
        rd_en_o = 1'b0;
        wr_en_o = 1'b0;
        byte_sel_o = 2'h3;
        wr_data_o = 8'h00;
        {por_o, select_o, auth_ok_o, auth_fail_o, quiet_o} = 5'h00;
    end

    // one request held over exactly one taking edge
    task automatic cmd(input logic rd, input logic [1:0] sel, input logic [7:0] d);
    begin
        @(negedge clock_i);
        rd_en_o = rd;
        wr_en_o = ~rd;
        byte_sel_o = sel;
        wr_data_o = d;
        @(negedge clock_i);
        rd_en_o = 1'b0;
        wr_en_o = 1'b0;
        wr_data_o = ~d; // released bus must not look like the last value
    end
    endtask

    // one-cycle event; exchange results are sent after a select
    task automatic ev(input logic [4:0] e);
    begin
        @(negedge clock_i);
        {por_o, select_o, auth_ok_o, auth_fail_o, quiet_o} = e;
        @(negedge clock_i);
        {por_o, select_o, auth_ok_o, auth_fail_o, quiet_o} = 5'h00;
    end
    endtask
endmodule // tcb_reader_model
`default_nettype wire

// ==== bench/tcb_config_bank_bench.sv ====
// self-checking bench of the configuration byte bank
// assumes tcb_reader_model drives the command and event side
`timescale 1ns/100ps
`default_nettype none
`include "tcb_consts.svh"

module tcb_config_bank_bench;
    localparam logic [1:0] MEM_CODE = `TCB_MEM_2048;
    typedef struct packed {
        logic [7:0] mode;
        logic auth, tag_speaks_first, bip, pig;
        logic [6:0] len;
        logic [5:0] last;
        logic lock, srd, swr;
    } tcb_row_t;
    logic clock_i, rst_b_i, rd_en, wr_en, rdv, wack, wref, seld, amode;
    logic tag_speaks_first, bip, pig, sr, sw, lck;
    logic [1:0] sel;
    logic [7:0] wdat, rdat;
    logic por, sok, aok, afail, quiet;
    logic [6:0] blen;
    logic [5:0] lpg;
    int num_errors, compares;
    tcb_row_t rows [5];
    tcb_row_t r;

    tcb_reader_model rdr (.clock_i(clock_i), .rd_en_o(rd_en), .wr_en_o(wr_en),
        .byte_sel_o(sel), .wr_data_o(wdat), .por_o(por), .select_o(sok), .auth_ok_o(aok),
        .auth_fail_o(afail), .quiet_o(quiet));
    tcb_config_bank #(.MEM_SIZE_CODE(MEM_CODE)) uut (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .por_i(por), .rd_en_i(rd_en), .wr_en_i(wr_en), .byte_sel_i(sel), .wr_data_i(wdat),
        .rd_data_o(rdat), .rd_valid_o(rdv), .wr_ack_o(wack), .wr_refused_o(wref),
        .select_ok_i(sok), .auth_ok_i(aok), .auth_fail_i(afail), .quiet_i(quiet),
        .selected_o(seld), .auth_mode_o(amode), .ttf_enable_o(tag_speaks_first), .uplink_biphase_o(bip),
        .pigeon_race_o(pig), .bit_len_o(blen), .ttf_last_page_o(lpg),
        .secret_rd_ok_o(sr), .secret_wr_ok_o(sw), .config_locked_o(lck));

    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic close_out();
    begin
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    begin
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
        end
    end
    endtask

    task automatic chk_flags(input logic [15:0] got, input logic [15:0] exp);
    begin
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t flags %h expected %h", $time, got, exp);
        end
    end
    endtask

    // reset held four cycles; stored bytes return to delivery state
    task automatic do_reset();
    begin
        @(negedge clock_i);
        rst_b_i = 1'b0;
        repeat (4) @(negedge clock_i);
        rst_b_i = 1'b1;
    end
    endtask

    // write, then expect {ack, refused} half a cycle after the taking edge
    task automatic wr(input logic [1:0] s, input logic [7:0] d, input logic [1:0] exp);
    begin
        rdr.cmd(1'b0, s, d);
        // answer pulses stand only until the next rising edge
        chk_flags({14'h0, wack, wref}, {14'h0, exp});
    end
    endtask

    task automatic rd(input logic [1:0] s, input logic [7:0] exp);
    begin
        rdr.cmd(1'b1, s, 8'h00);
        chk_flags({15'h0, rdv}, 16'h0001);
        chk_byte(rdat, exp);
    end
    endtask

    initial
    begin
        #(3000 * 25);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out();
    end

    initial
    begin
        rst_b_i = 1'b0;
        num_errors = 0;
        compares = 0;
        rows[0] = '{8'h04, 0, 1, 0, 0, `TCB_BITLEN_4K, `TCB_TTF_PAGE_5, 0, 1, 1};
        rows[1] = '{8'h69, 0, 1, 1, 0, `TCB_BITLEN_2K, `TCB_TTF_PAGE_7, 0, 1, 0};
        rows[2] = '{8'h9c, 1, 1, 0, 0, `TCB_BITLEN_8K, `TCB_TTF_FIRST_PAGE, 0, 1, 1};
        rows[3] = '{8'hb5, 1, 1, 0, 1, `TCB_BITLEN_2K, `TCB_TTF_PAGE_5, 0, 0, 0};
        rows[4] = '{8'h42, 0, 0, 1, 0, `TCB_BITLEN_4K, `TCB_TTF_FIRST_PAGE, 1, 1, 1};
        for (int i = 0; i < 5; i++)
        begin
            r = rows[i];
            do_reset();
            wr(2'h1, r.mode, 2'b10);
            rd(2'h1, r.mode);
            chk_flags({13'h0, amode, lck, tag_speaks_first}, 16'h0000);
            rdr.ev(5'h10);
            repeat (2) @(negedge clock_i);
            chk_flags({amode, lck, sr, sw, tag_speaks_first, 11'h0},
                {r.auth, r.lock, r.srd, r.swr, r.tag_speaks_first, 11'h0});
            // decoded settings show even with talks-first off
            chk_flags({1'b0, bip, pig, blen, lpg},
                {1'b0, r.bip, r.pig, r.len, r.last});
            rdr.ev(5'h08);
            @(negedge clock_i);
            chk_flags({15'h0, seld}, {15'h0, ~r.auth});
            rdr.ev(5'h02);
            rdr.ev(5'h04);
            @(negedge clock_i);
            chk_flags({15'h0, seld}, {15'h0, ~r.auth});
            rdr.ev(5'h01);
            rdr.ev(5'h08);
            rdr.ev(5'h04);
            @(negedge clock_i);
            chk_flags({15'h0, seld}, 16'h0001);
        end
        // active lock now set by the last row
        wr(2'h1, 8'h00, 2'b01);
        rd(2'h1, 8'h42);
        wr(2'h2, 8'h0f, 2'b10);
        wr(2'h2, 8'hf0, 2'b10);
        wr(2'h2, 8'h00, 2'b10);
        rd(2'h2, 8'hff);
        wr(2'h0, 8'hff, 2'b01);
        rd(2'h0, {6'h00, MEM_CODE});
        wr(2'h3, 8'h5a, 2'b01);
        do_reset();
        chk_flags({rdat, rdv, wack, wref, seld, amode, lck, sr, sw}, 16'h0003);
        wr(2'h2, 8'h0f, 2'b10);
        wr(2'h2, 8'h30, 2'b10);
        rd(2'h2, 8'h30);
        // lock bit sticks in the stored byte before any power-on
        wr(2'h1, 8'h02, 2'b10);
        wr(2'h1, 8'h00, 2'b10);
        rd(2'h1, 8'h02);
        close_out();
    end
endmodule // tcb_config_bank_bench
`default_nettype wire
